// *** shared/gptcp_pkg.sv ***
// Constants, register map and mode set of the capture/compare/PWM timer.
// Assumes a 32-bit register bus with word-aligned byte addresses.
package gptcp_pkg;
    // Register byte offsets
    localparam logic [11:0] CFG_OFS = 12'h000;
    localparam logic [11:0] MODE_OFS = 12'h004;
    localparam logic [11:0] CTL_OFS = 12'h00C;
    localparam logic [11:0] IMR_OFS = 12'h018;
    localparam logic [11:0] RIS_OFS = 12'h01C;
    localparam logic [11:0] MIS_OFS = 12'h020;
    localparam logic [11:0] ICR_OFS = 12'h024;
    localparam logic [11:0] ILR_OFS = 12'h028;
    localparam logic [11:0] MATCH_OFS = 12'h030;
    localparam logic [11:0] PRE_OFS = 12'h038;
    localparam logic [11:0] CNT_OFS = 12'h048;
    // Mode register fields
    localparam int MODE_MR_LSB = 0;
    localparam int MODE_CMR_BIT = 2;
    localparam int MODE_AMS_BIT = 3;
    // Control register fields
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_EVT_LSB = 2;
    localparam int CTL_RTCOVR_BIT = 4;
    localparam int CTL_INV_BIT = 6;
    // Status, mask and clear bit positions
    localparam int FLAG_TO = 0;
    localparam int FLAG_EM = 1;
    localparam int FLAG_ET = 2;
    localparam int FLAG_RTC = 3;
    // Reset and load values
    localparam logic [31:0] ILR_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] MATCH_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] RTC_FIRST = 32'h0000_0001;
    // Encodings
    localparam logic [2:0] CFG_32 = 3'h0;
    localparam logic [2:0] CFG_RTC = 3'h1;
    localparam int CFG_16_BIT = 2;
    localparam logic [1:0] MR_ONESHOT = 2'h1;
    localparam logic [1:0] MR_PERIODIC = 2'h2;
    localparam logic [1:0] MR_CAPTURE = 2'h3;
    localparam logic [1:0] EVT_RISE = 2'h0;
    localparam logic [1:0] EVT_FALL = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // RTC input rate in Hz; dividing by it gives one tick per second
    localparam int RTC_CLK_HZ = 32768;

    typedef enum logic [3:0] {
        GPTCP_OFF, GPTCP_OS32, GPTCP_PER32, GPTCP_RTC, GPTCP_OS16,
        GPTCP_PER16, GPTCP_ECNT, GPTCP_ETIME, GPTCP_PWM
    } gptcp_mode_t;
endpackage

// *** core/gptcp_timer.sv ***
// Timer with 32/16-bit one-shot, periodic, RTC, edge count, edge time
// and PWM modes behind an AXI4-Lite register slave.
// Assumes the pin input is synchronous to clk; one clock, async reset.
//
// Operation
// - Edge count stops itself at match
// - Edge time free down-counts from load value
// - Edge time captures rising or falling only
// - Capture select picks edge time; event field
// - Edge capture copies count, sets flags
// - Edge time keeps counting, reloads at zero
// - Captured value held until next edge
// - No prescaling in edge time, PWM
// - PWM selected by mode bits, period load
// - PWM reloads after zero, runs until disabled
// - PWM mode sets no status flags
// - PWM high at load, low at match
// - Load rewrite takes effect next cycle
// - Clear write clears raw and masked flag
// - One-shot stops after timeout; periodic continues
// - RTC rolls to zero at match, continues
// - Each selected edge decrements count once
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gptcp_timer
    import gptcp_pkg::*;
#(
    parameter int RTC_DIV = RTC_CLK_HZ
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic capture_compare_pin_i,
    output logic capture_compare_pin_o,
    output logic capture_compare_pin_oe
);
    localparam int DIV_W = $clog2(RTC_DIV);

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic gptcp_mode_t decode(input logic [2:0] cfg,
            input logic [3:0] md);
        logic [1:0] mr;
        mr = md[MODE_MR_LSB +: 2];
        if (cfg == CFG_RTC) begin
            return GPTCP_RTC;
        end else if (cfg == CFG_32) begin
            return mr == MR_ONESHOT ? GPTCP_OS32 :
                   mr == MR_PERIODIC ? GPTCP_PER32 : GPTCP_OFF;
        end else if (!cfg[CFG_16_BIT]) begin
            return GPTCP_OFF;
        end else if (md[MODE_AMS_BIT] && !md[MODE_CMR_BIT]
                     && mr == MR_PERIODIC) begin
            return GPTCP_PWM;
        end else if (mr == MR_CAPTURE) begin
            return md[MODE_CMR_BIT] ? GPTCP_ETIME : GPTCP_ECNT;
        end else begin
            return mr == MR_ONESHOT ? GPTCP_OS16 :
                   mr == MR_PERIODIC ? GPTCP_PER16 : GPTCP_OFF;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic aw_got_ff, w_got_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_go;
    logic [31:0] rd_val;
    logic rd_ok;

    assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a[11:2] == o[11:2];
    endfunction

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    function automatic logic wr_ok(input logic [11:0] a);
        return hit(a, CFG_OFS) || hit(a, MODE_OFS) || hit(a, CTL_OFS)
            || hit(a, IMR_OFS) || hit(a, ICR_OFS) || hit(a, ILR_OFS)
            || hit(a, MATCH_OFS) || hit(a, PRE_OFS);
    endfunction

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [2:0] cfg_ff;
    logic [3:0] mode_ff, imr_ff, ris_ff, set_vec, icr_clr;
    logic [6:0] ctl_ff;
    logic [31:0] ilr_ff, match_ff, cnt_ff, nxt_ilr;
    logic [7:0] pre_ff;
    logic [15:0] cap_ff;
    logic ctl_wr, ilr_wr, hw_stop;
    gptcp_mode_t cur;

    assign cur = decode(cfg_ff, mode_ff);
    assign ctl_wr = wr_go && hit(awaddr_ff, CTL_OFS);
    assign ilr_wr = wr_go && hit(awaddr_ff, ILR_OFS);
    assign nxt_ilr = merge(ilr_ff, wdata_ff, wstrb_ff);
    assign icr_clr = (wr_go && hit(awaddr_ff, ICR_OFS) && wstrb_ff[0])
        ? wdata_ff[3:0] : 4'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_ff <= 3'h0;
            mode_ff <= 4'h0;
            imr_ff <= 4'h0;
            ilr_ff <= ILR_RST;
            match_ff <= MATCH_RST;
            pre_ff <= 8'h00;
        end else if (wr_go) begin
            if (hit(awaddr_ff, CFG_OFS)) begin
                cfg_ff <= 3'(merge({29'h0, cfg_ff}, wdata_ff, wstrb_ff));
            end
            if (hit(awaddr_ff, MODE_OFS)) begin
                mode_ff <= 4'(merge({28'h0, mode_ff}, wdata_ff, wstrb_ff));
            end
            if (hit(awaddr_ff, IMR_OFS)) begin
                imr_ff <= 4'(merge({28'h0, imr_ff}, wdata_ff, wstrb_ff));
            end
            if (ilr_wr) begin
                ilr_ff <= nxt_ilr;
            end
            if (hit(awaddr_ff, MATCH_OFS)) begin
                match_ff <= merge(match_ff, wdata_ff, wstrb_ff);
            end
            if (hit(awaddr_ff, PRE_OFS)) begin
                pre_ff <= 8'(merge({24'h0, pre_ff}, wdata_ff, wstrb_ff));
            end
        end
    end

    // A software write of the enable wins over a same-cycle hardware stop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_ff <= 7'h00;
        end else if (ctl_wr) begin
            ctl_ff <= 7'(merge({25'h0, ctl_ff}, wdata_ff, wstrb_ff));
        end else if (hw_stop) begin
            ctl_ff[CTL_EN_BIT] <= 1'b0;
        end
    end

    // Set wins over a same-cycle clear; masked view is derived on read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ris_ff <= 4'h0;
        end else begin
            ris_ff <= (ris_ff & ~icr_clr) | set_vec;
        end
    end

    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        case (s_axi_araddr[11:2])
            CFG_OFS[11:2]: rd_val = {29'h0, cfg_ff};
            MODE_OFS[11:2]: rd_val = {28'h0, mode_ff};
            CTL_OFS[11:2]: rd_val = {25'h0, ctl_ff};
            IMR_OFS[11:2]: rd_val = {28'h0, imr_ff};
            RIS_OFS[11:2]: rd_val = {28'h0, ris_ff};
            MIS_OFS[11:2]: rd_val = {28'h0, ris_ff & imr_ff};
            ICR_OFS[11:2]: rd_val = 32'h0000_0000;
            ILR_OFS[11:2]: rd_val = ilr_ff;
            MATCH_OFS[11:2]: rd_val = match_ff;
            PRE_OFS[11:2]: rd_val = {24'h0, pre_ff};
            CNT_OFS[11:2]: rd_val = cur == GPTCP_ETIME ? {16'h0, cap_ff}
                                                       : cnt_ff;
            default: rd_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Counting
    logic en_q_ff, pin_q_ff, plvl_ff;
    logic [7:0] ps_ff;
    logic [DIV_W-1:0] div_ff;
    logic run, start, act, is16, rise, fall, ecnt_edge, etime_edge;
    logic dec_tick, rtc_tick, zero, em_hit, os_pre, nxt_plvl;
    logic [31:0] ld_cur, ld_new, cnt_dec;
    logic [1:0] evt;

    assign run = ctl_ff[CTL_EN_BIT];
    assign start = run && !en_q_ff;
    assign act = run && !start;
    assign is16 = cfg_ff[CFG_16_BIT];
    assign ld_cur = is16 ? {16'h0, ilr_ff[15:0]} : ilr_ff;
    assign ld_new = is16 ? {16'h0, nxt_ilr[15:0]} : nxt_ilr;
    assign cnt_dec = cnt_ff - 32'h0000_0001;
    assign zero = cnt_ff == 32'h0000_0000;
    assign evt = ctl_ff[CTL_EVT_LSB +: 2];
    // Edges are seen one clock after the pin moves; relies on each level
    // lasting at least one clock so no edge is missed.
    assign rise = capture_compare_pin_i && !pin_q_ff;
    assign fall = !capture_compare_pin_i && pin_q_ff;
    assign ecnt_edge = evt == EVT_RISE ? rise : evt == EVT_FALL ? fall
                                              : rise || fall;
    assign etime_edge = evt == EVT_RISE ? rise
                      : evt == EVT_FALL ? fall : 1'b0;
    assign os_pre = cur == GPTCP_OS16 || cur == GPTCP_PER16;
    assign dec_tick = os_pre ? ps_ff == 8'h00 : 1'b1;
    assign rtc_tick = rise && div_ff == DIV_W'(RTC_DIV - 1);
    assign em_hit = cnt_dec == {16'h0, match_ff[15:0]};

    always_comb begin
        set_vec = 4'h0;
        if (act) begin
            case (cur)
                GPTCP_OS32, GPTCP_PER32, GPTCP_OS16, GPTCP_PER16:
                    set_vec[FLAG_TO] = zero;
                GPTCP_ECNT: set_vec[FLAG_EM] = ecnt_edge && em_hit;
                GPTCP_ETIME: set_vec[FLAG_ET] = etime_edge;
                GPTCP_RTC: set_vec[FLAG_RTC] = rtc_tick && cnt_ff == match_ff;
                default: set_vec = 4'h0;
            endcase
        end
    end
    assign hw_stop = set_vec[FLAG_EM] || (set_vec[FLAG_TO]
        && (cur == GPTCP_OS32 || cur == GPTCP_OS16));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            en_q_ff <= 1'b0;
            pin_q_ff <= 1'b0;
        end else begin
            en_q_ff <= run;
            pin_q_ff <= capture_compare_pin_i;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= ILR_RST;
        end else if (start) begin
            cnt_ff <= cur == GPTCP_RTC ? RTC_FIRST : ld_cur;
        end else if (act) begin
            case (cur)
                GPTCP_RTC: begin
                    if (rtc_tick) begin
                        cnt_ff <= cnt_ff == match_ff ? 32'h0000_0000
                                : cnt_ff + 32'h0000_0001;
                    end
                end
                GPTCP_ECNT: begin
                    if (ecnt_edge) begin
                        cnt_ff <= em_hit ? ld_cur : cnt_dec;
                    end
                end
                GPTCP_OFF: cnt_ff <= cnt_ff;
                default: begin
                    if (ilr_wr) begin
                        cnt_ff <= ld_new;
                    end else if (zero) begin
                        cnt_ff <= ld_cur;
                    end else if (dec_tick) begin
                        cnt_ff <= cnt_dec;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ps_ff <= 8'h00;
            div_ff <= '0;
        end else begin
            if (start || zero || !os_pre) begin
                ps_ff <= pre_ff;
            end else if (act) begin
                ps_ff <= ps_ff == 8'h00 ? pre_ff : ps_ff - 8'h01;
            end
            if (start || cur != GPTCP_RTC) begin
                div_ff <= '0;
            end else if (rise) begin
                div_ff <= rtc_tick ? '0 : div_ff + DIV_W'(1);
            end
        end
    end

    // Capture register holds until the next selected edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_ff <= 16'hFFFF;
        end else if (set_vec[FLAG_ET]) begin
            cap_ff <= cnt_ff[15:0];
        end
    end

    // Start value wins if load and match are equal
    always_comb begin
        nxt_plvl = plvl_ff;
        if (cnt_ff == ld_cur) begin
            nxt_plvl = 1'b1;
        end else if (cnt_ff == {16'h0, match_ff[15:0]}) begin
            nxt_plvl = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            plvl_ff <= 1'b0;
            capture_compare_pin_o <= 1'b0;
            capture_compare_pin_oe <= 1'b0;
        end else begin
            plvl_ff <= cur == GPTCP_PWM && run ? nxt_plvl : 1'b0;
            capture_compare_pin_oe <= cur == GPTCP_PWM;
            capture_compare_pin_o <= cur == GPTCP_PWM
                && ((run && nxt_plvl) ^ ctl_ff[CTL_INV_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    ecnt_stop_a: assert property (
        set_vec[FLAG_EM] && !ctl_wr |=> !run && cnt_ff == $past(ld_cur))
        else $error("edge count did not stop and reload at match");
    ecnt_dec_a: assert property (
        act && cur == GPTCP_ECNT && ecnt_edge && !em_hit
        |=> cnt_ff == $past(cnt_dec))
        else $error("edge count did not step by one");
    etime_cap_a: assert property (
        act && cur == GPTCP_ETIME && etime_edge
        |=> cap_ff == $past(cnt_ff[15:0]) && ris_ff[FLAG_ET])
        else $error("edge time capture lost");
    cap_hold_a: assert property (
        !set_vec[FLAG_ET] |=> $stable(cap_ff))
        else $error("captured value changed without an edge");
    etime_free_a: assert property (
        act && (cur == GPTCP_ETIME || cur == GPTCP_PWM) && !zero
        && !ilr_wr && !ctl_wr |=> cnt_ff == $past(cnt_ff) - 32'h0000_0001)
        else $error("edge time or PWM counter did not step each clock");
    reload_zero_a: assert property (
        act && cur == GPTCP_ETIME && zero && !ilr_wr && !ctl_wr
        |=> cnt_ff == $past(ld_cur))
        else $error("no reload from zero");
    ilr_now_a: assert property (
        act && cur == GPTCP_PWM && ilr_wr && !ctl_wr
        |=> cnt_ff == {16'h0, ilr_ff[15:0]})
        else $error("new load value not taken");
    pwm_quiet_a: assert property (
        cur == GPTCP_PWM |-> set_vec == 4'h0)
        else $error("status flag set in PWM mode");
    pwm_high_a: assert property (
        cur == GPTCP_PWM && run && cnt_ff == ld_cur && !ctl_wr
        |=> capture_compare_pin_o == !ctl_ff[CTL_INV_BIT])
        else $error("PWM level wrong at start value");
    // Clear bits that no same-cycle set overrides
    logic [3:0] clr_eff;
    assign clr_eff = icr_clr & ~set_vec;
    icr_clear_a: assert property (
        clr_eff != 4'h0 |=> (ris_ff & $past(clr_eff)) == 4'h0)
        else $error("flag survived a clear");
    oneshot_stop_a: assert property (
        set_vec[FLAG_TO] && cur == GPTCP_OS16 && !ctl_wr |=> !run)
        else $error("one-shot kept running after timeout");
    rtc_roll_a: assert property (
        set_vec[FLAG_RTC] |=> cnt_ff == 32'h0000_0000)
        else $error("RTC did not roll over at match");

    ecnt_done_c: cover property (set_vec[FLAG_EM]);
    etime_cap_c: cover property (set_vec[FLAG_ET] ##[1:40] set_vec[FLAG_ET]);
    pwm_pulse_c: cover property (
        cur == GPTCP_PWM && capture_compare_pin_o ##1 !capture_compare_pin_o);
    per_to_c: cover property (set_vec[FLAG_TO] && cur == GPTCP_PER16);
endmodule
`default_nettype wire

// *** sim/gptcp_pin_model.sv ***
// Pin-side partner: drives edges or a slow clock into the timer pin.
// Assumes the timer samples its pin input on every rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module gptcp_pin_model (
    input wire logic clk,
    output logic pin
);
    initial pin = 1'h0;
    // Each level is held two clocks or more, so no edge can be missed
    task automatic toggle(input int n, input int hold);
        repeat (n) begin
            repeat (hold < 2 ? 2 : hold) @(posedge clk);
            pin <= ~pin;
        end
    endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the capture/compare/PWM timer.
// Assumes the pin partner model; RTC divider shortened to 4 input edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top import gptcp_pkg::*;;
    logic clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pin, pin_o, pin_oe;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    int n_mismatch = 0;
    int checks = 0;
    gptcp_timer #(.RTC_DIV(4)) i_gptcp_timer (
        .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .capture_compare_pin_i(pin),
        .capture_compare_pin_o(pin_o), .capture_compare_pin_oe(pin_oe)
    );
    gptcp_pin_model pin_mdl (.clk(clk), .pin(pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hang;
        n_mismatch++;
        $display("MISMATCH %0t bus wait ran out", $time);
        wrap_up();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Address and data offered together; each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (++n > 1000) hang();
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            if (++n > 1000) hang();
        end while (!rvalid);
        rd_v = rdata;
        rsp = rresp;
        rready <= 1'h0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_v, exp);
    endtask
    // Counts high cycles of the pin output over exactly 100 clocks
    task automatic hi_chk(input int exp);
        int h;
        h = 0;
        tick(12);
        repeat (100) begin
            @(posedge clk);
            if (pin_o === 1'h1) h++;
        end
        chk(32'(h), 32'(exp));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rchk(ILR_OFS, ILR_RST);
        rchk(MATCH_OFS, MATCH_RST);
        rchk(CNT_OFS, 32'hFFFF_FFFF);
        rchk(12'h100, 32'h0000_0000);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(RIS_OFS, 32'h0000_000F);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        rchk(RIS_OFS, 32'h0000_0000);
        chk({31'h0, pin_oe}, 32'h0000_0000);
    endtask
    task automatic t_etime;
        logic [31:0] c1;
        wr(CFG_OFS, 32'h0000_0004);
        wr(PRE_OFS, 32'h0000_0005);
        wr(MODE_OFS, 32'h0000_0007);
        wr(IMR_OFS, 32'h0000_0004);
        wr(CTL_OFS, 32'h0000_0001);
        fork
            pin_mdl.toggle(3, 20);
            begin
                tick(26);
                rd(CNT_OFS);
                c1 = rd_v;
                chk({8'h0, c1[31:8]}, 32'h0000_00FF);
                tick(16);
                rchk(CNT_OFS, c1);
            end
        join
        tick(4);
        rchk(CNT_OFS, c1 - 32'h0000_0028);
        rchk(MIS_OFS, 32'h0000_0004);
        // A short period while running must wrap well inside 60 clocks
        wr(ILR_OFS, 32'h0000_0010);
        pin_mdl.toggle(2, 30);
        tick(4);
        rd(CNT_OFS);
        chk({31'h0, rd_v > 32'h0000_0010}, 32'h0000_0000);
        wr(CTL_OFS, 32'h0000_0000);
        wr(ICR_OFS, 32'h0000_000F);
    endtask
    task automatic t_timer;
        wr(CFG_OFS, {29'h0, CFG_32});
        wr(MODE_OFS, {30'h0, MR_ONESHOT});
        wr(ILR_OFS, 32'h0000_0005);
        wr(IMR_OFS, 32'h0000_0001);
        wr(CTL_OFS, 32'h0000_0001);
        tick(20);
        rchk(MIS_OFS, 32'h0000_0001);
        rchk(CTL_OFS, 32'h0000_0000);
        wr(ICR_OFS, 32'h0000_0001);
        rchk(RIS_OFS, 32'h0000_0000);
        rchk(MIS_OFS, 32'h0000_0000);
        wr(MODE_OFS, {30'h0, MR_PERIODIC});
        wr(CTL_OFS, 32'h0000_0001);
        tick(20);
        wr(ICR_OFS, 32'h0000_0001);
        tick(20);
        rchk(RIS_OFS, 32'h0000_0001);
        rchk(CTL_OFS, 32'h0000_0001);
        wr(CTL_OFS, 32'h0000_0000);
        wr(ICR_OFS, 32'h0000_000F);
    endtask
    task automatic t_ecount;
        wr(CFG_OFS, 32'h0000_0004);
        wr(MODE_OFS, 32'h0000_0003);
        wr(CTL_OFS, 32'h0000_000C);
        wr(ILR_OFS, 32'h0000_000A);
        wr(MATCH_OFS, 32'h0000_0006);
        wr(IMR_OFS, 32'h0000_0002);
        wr(CTL_OFS, 32'h0000_000D);
        pin_mdl.toggle(6, 3);
        tick(4);
        rchk(MIS_OFS, 32'h0000_0002);
        rchk(CTL_OFS, 32'h0000_000C);
        rchk(CNT_OFS, 32'h0000_000A);
        wr(ICR_OFS, 32'h0000_0002);
        rchk(RIS_OFS, 32'h0000_0000);
    endtask
    task automatic t_pwm;
        wr(MODE_OFS, 32'h0000_000A);
        wr(ILR_OFS, 32'h0000_0009);
        wr(MATCH_OFS, 32'h0000_0002);
        wr(CTL_OFS, 32'h0000_0001);
        hi_chk(70);
        chk({31'h0, pin_oe}, 32'h0000_0001);
        wr(CTL_OFS, 32'h0000_0041);
        hi_chk(30);
        wr(ILR_OFS, 32'h0000_0013);
        hi_chk(15);
        rchk(RIS_OFS, 32'h0000_0000);
        wr(CTL_OFS, 32'h0000_0000);
    endtask
    // Prescale of 3 holds the count for four clocks per step
    task automatic t_t16;
        wr(CFG_OFS, 32'h0000_0004);
        wr(MODE_OFS, {30'h0, MR_ONESHOT});
        wr(PRE_OFS, 32'h0000_0003);
        wr(ILR_OFS, 32'h0000_0004);
        wr(IMR_OFS, 32'h0000_0001);
        wr(CTL_OFS, 32'h0000_0001);
        rchk(CNT_OFS, 32'h0000_0004);
        tick(20);
        rchk(RIS_OFS, 32'h0000_0001);
        rchk(CTL_OFS, 32'h0000_0000);
        wr(ICR_OFS, 32'h0000_0001);
        wr(MODE_OFS, {30'h0, MR_PERIODIC});
        wr(CTL_OFS, 32'h0000_0001);
        tick(40);
        rchk(RIS_OFS, 32'h0000_0001);
        rchk(CTL_OFS, 32'h0000_0001);
        wr(CTL_OFS, 32'h0000_0000);
        wr(ICR_OFS, 32'h0000_000F);
    endtask
    task automatic t_rtc;
        wr(CFG_OFS, {29'h0, CFG_RTC});
        wr(MATCH_OFS, 32'h0000_0002);
        wr(IMR_OFS, 32'h0000_0008);
        wr(CTL_OFS, 32'h0000_0011);
        pin_mdl.toggle(16, 2);
        tick(4);
        rchk(CNT_OFS, 32'h0000_0000);
        rchk(MIS_OFS, 32'h0000_0008);
        pin_mdl.toggle(16, 2);
        tick(4);
        rchk(CNT_OFS, 32'h0000_0002);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        rstn = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        tick(12);
        rstn <= 1'h1;
        t_reset();
        t_etime();
        t_timer();
        t_ecount();
        t_pwm();
        t_t16();
        t_rtc();
        wrap_up();
    end
endmodule
`default_nettype wire
